// ===== mac_alu_pkg.sv
// Package for the multiply/ALU datapath: register map, field layout,
// operation codes, state encoding and fixed values.
// Assumes a 32-bit APB register bus with byte addresses.
package mac_alu_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] OPERAND_OFS = 8'h08;
	localparam logic [7:0] DATA_OFS = 8'h0c;
	localparam logic [7:0] CMD_OFS = 8'h10;
	localparam logic [7:0] PROD_OFS = 8'h14;
	localparam logic [7:0] ACC_OFS = 8'h18;
	localparam logic [7:0] STORE_OFS = 8'h1c;
	localparam logic [7:0] TARGET_OFS = 8'h20;

	// Control register fields
	localparam int CTRL_PSEL_LSB = 0;
	localparam int CTRL_SAT_BIT = 2;
	localparam int CTRL_SXM_BIT = 3;
	localparam logic [1:0] PSEL_RESET = 2'h0;
	localparam logic SAT_RESET = 1'b0;
	localparam logic SXM_RESET = 1'b1;

	// Status register fields
	localparam int ST_CARRY_BIT = 0;
	localparam int ST_WRAP_BIT = 1;
	localparam int ST_TC_BIT = 2;
	localparam int ST_ZERO_BIT = 3;
	localparam logic CARRY_RESET = 1'b1;

	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_SHIFT_LSB = 5;
	localparam int CMD_RPT_LSB = 10;
	localparam int CMD_IMM_LSB = 16;
	localparam int OP_W = 5;
	localparam int SHIFT_W = 5;
	localparam int RPT_W = 6;
	localparam int IMM_W = 13;

	// Product shifter modes and amounts
	localparam logic [1:0] PSEL_NONE = 2'h0;
	localparam logic [1:0] PSEL_LEFT1 = 2'h1;
	localparam logic [1:0] PSEL_LEFT4 = 2'h2;
	localparam logic [1:0] PSEL_RIGHT6 = 2'h3;
	localparam int PSH_LEFT1 = 1;
	localparam int PSH_LEFT4 = 4;
	localparam int PSH_RIGHT6 = 6;

	// Accumulator limits and the high-accumulator shift count
	localparam logic [31:0] ACC_MAX = 32'h7fffffff;
	localparam logic [31:0] ACC_MIN = 32'h80000000;
	localparam logic [SHIFT_W-1:0] SHIFT_HIGH = 5'h10;

	// Operations started by a command write
	typedef enum logic [OP_W-1:0] {
		OP_NOP = 5'h00, OP_MPY = 5'h01, OP_UNSIGNED_MULTIPLY_OP = 5'h02, OP_MPYI = 5'h03,
		OP_MAC = 5'h04, OP_MULTIPLY_ACCUMULATE_MOVE_OP = 5'h05, OP_SPH = 5'h06, OP_SPL = 5'h07,
		OP_LPH = 5'h08, OP_LT = 5'h09, OP_LTP = 5'h0a, OP_LTA = 5'h0b,
		OP_LTS = 5'h0c, OP_LTD = 5'h0d, OP_ADD = 5'h0e, OP_SUB = 5'h0f,
		OP_ADD_WITH_CARRY_OP = 5'h10, OP_SUB_WITH_BORROW_OP = 5'h11, OP_LACC = 5'h12, OP_AND = 5'h13,
		OP_OR = 5'h14, OP_XOR = 5'h15, OP_LOAD_WITH_VARIABLE_SHIFT_OP = 5'h16, OP_ADD_WITH_VARIABLE_SHIFT_OP = 5'h17,
		OP_SUB_WITH_VARIABLE_SHIFT_OP = 5'h18, OP_BIT_TEST_VARIABLE_OP = 5'h19, OP_SFL = 5'h1a, OP_SFR = 5'h1b,
		OP_ROL = 5'h1c, OP_ROR = 5'h1d, OP_BCOND = 5'h1e, OP_BRANCH_TO_ACCUMULATOR_OP = 5'h1f
	} op_type;

	// Branch conditions, held in the shift field of a branch command
	localparam logic [SHIFT_W-1:0] COND_OV = 5'h00;
	localparam logic [SHIFT_W-1:0] COND_EQ = 5'h01;
	localparam logic [SHIFT_W-1:0] COND_C = 5'h02;
	localparam logic [SHIFT_W-1:0] COND_NC = 5'h03;

	// Sequencer states, Gray along idle -> run -> second multiply cycle
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_IMM2 = 2'b11
	} state_type;

endpackage

// ===== mac_alu.sv
// Multiply / accumulate datapath with product shifter and central ALU,
// reached over an APB slave. Assumes memory feeds coefficient and sample
// words combinationally on the cycle that the advance strobes are high.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps

module mac_alu
	import mac_alu_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Coefficient and sample streams
	input wire logic [15:0] i_coef_word,
	input wire logic [15:0] i_sample_word,
	output logic o_coef_advance,
	output logic o_sample_advance,
	// Sample move to next data address
	output logic o_move_we,
	output logic [15:0] o_move_data,
	// Branch result
	output logic o_branch_taken,
	output logic [15:0] o_branch_target,
	output logic o_busy
);

	// Registers
	logic [1:0] product_shift_select_r;
	logic saturate_enable_r;
	logic sxm_r;
	logic carry_r;
	logic arith_wrap_flag_r;
	logic tc_r;
	logic [15:0] multiplier_operand_reg_r;
	logic [15:0] data_r;
	logic [31:0] product_reg_r;
	logic [31:0] acc_r;
	logic [15:0] store_r;
	op_type op_r;
	logic [SHIFT_W-1:0] shift_r;
	logic [RPT_W-1:0] rpt_r;
	logic [IMM_W-1:0] imm_r;
	state_type st_r;
	state_type st_nxt;
	logic move_we_r;
	logic [15:0] move_data_r;
	logic branch_r;
	logic [15:0] target_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// APB decode
	wire logic [7:0] addr_lo = i_paddr[7:0];
	wire logic apb_acc = i_psel && i_penable;
	wire logic hit_ctrl = (addr_lo == CTRL_OFS);
	wire logic hit_status = (addr_lo == STATUS_OFS);
	wire logic hit_operand = (addr_lo == OPERAND_OFS);
	wire logic hit_data = (addr_lo == DATA_OFS);
	wire logic hit_cmd = (addr_lo == CMD_OFS);
	wire logic hit_prod = (addr_lo == PROD_OFS);
	wire logic hit_acc = (addr_lo == ACC_OFS);
	wire logic hit_store = (addr_lo == STORE_OFS);
	wire logic hit_target = (addr_lo == TARGET_OFS);
	wire logic hit_any = hit_ctrl | hit_status | hit_operand | hit_data | hit_cmd | hit_prod | hit_acc |
		hit_store | hit_target;
	wire logic cmd_stall = i_pwrite && hit_cmd && (st_r != ST_IDLE);
	wire logic apb_done = apb_acc && !cmd_stall;
	wire logic wr_en = apb_done && i_pwrite;
	wire logic wr_ctrl = wr_en && hit_ctrl;
	wire logic wr_status = wr_en && hit_status;
	wire logic wr_operand = wr_en && hit_operand;
	wire logic wr_data = wr_en && hit_data;
	wire logic wr_cmd = wr_en && hit_cmd;

	// Sequencer decode
	wire logic exec = ((st_r == ST_RUN) && (op_r != OP_MPYI)) || (st_r == ST_IMM2);
	wire logic is_mac = (op_r == OP_MAC) || (op_r == OP_MULTIPLY_ACCUMULATE_MOVE_OP);
	wire logic last_pass = !is_mac || (rpt_r == '0);

	// Product shifter; the register itself is never rewritten here
	logic [31:0] pshift;
	always_comb begin
		case (product_shift_select_r)
			PSEL_NONE: pshift = product_reg_r;
			PSEL_LEFT1: pshift = product_reg_r << PSH_LEFT1;
			PSEL_LEFT4: pshift = product_reg_r << PSH_LEFT4;
			PSEL_RIGHT6: pshift = 32'($signed(product_reg_r) >>> PSH_RIGHT6);
			default: pshift = product_reg_r;
		endcase
	end

	// Multiplier operands and product
	wire logic [15:0] imm_ext = {{(16-IMM_W){imm_r[IMM_W-1]}}, imm_r};
	wire logic [15:0] mult_a = is_mac ? i_coef_word : multiplier_operand_reg_r;
	wire logic [15:0] mult_b = is_mac ? i_sample_word : ((op_r == OP_MPYI) ? imm_ext : data_r);
	wire logic [31:0] prod_s = {{16{mult_a[15]}}, mult_a} * {{16{mult_b[15]}}, mult_b};
	wire logic [31:0] prod_u = {16'h0000, mult_a} * {16'h0000, mult_b};
	wire logic [31:0] product = (op_r == OP_UNSIGNED_MULTIPLY_OP) ? prod_u : prod_s;

	// Input scaling shifter, count from command or operand register
	wire logic var_shift = (op_r == OP_LOAD_WITH_VARIABLE_SHIFT_OP) || (op_r == OP_ADD_WITH_VARIABLE_SHIFT_OP) || (op_r == OP_SUB_WITH_VARIABLE_SHIFT_OP);
	wire logic [SHIFT_W-1:0] ish_cnt = var_shift ? {1'b0, multiplier_operand_reg_r[3:0]} : shift_r;
	wire logic [31:0] ish_ext = sxm_r ? {{16{data_r[15]}}, data_r} : {16'h0000, data_r};
	wire logic [31:0] ishift = ish_ext << ish_cnt;

	// Central ALU operand selection and classes
	wire logic use_prod = is_mac || (op_r == OP_LTP) || (op_r == OP_LTA) || (op_r == OP_LTS) || (op_r == OP_LTD);
	wire logic [31:0] alu_b = use_prod ? pshift : ishift;
	wire logic is_add = is_mac || (op_r == OP_LTA) || (op_r == OP_LTD) || (op_r == OP_ADD) || (op_r == OP_ADD_WITH_CARRY_OP) ||
		(op_r == OP_ADD_WITH_VARIABLE_SHIFT_OP);
	wire logic is_sub = (op_r == OP_LTS) || (op_r == OP_SUB) || (op_r == OP_SUB_WITH_BORROW_OP) || (op_r == OP_SUB_WITH_VARIABLE_SHIFT_OP);
	wire logic is_load = (op_r == OP_LTP) || (op_r == OP_LACC) || (op_r == OP_LOAD_WITH_VARIABLE_SHIFT_OP);
	wire logic is_logic = (op_r == OP_AND) || (op_r == OP_OR) || (op_r == OP_XOR);
	wire logic is_shift = (op_r == OP_SFL) || (op_r == OP_SFR) || (op_r == OP_ROL) || (op_r == OP_ROR);
	wire logic loads_operand = (op_r == OP_LT) || (op_r == OP_LTP) || (op_r == OP_LTA) || (op_r == OP_LTS) ||
		(op_r == OP_LTD);

	// Adder with prior carry for the carry-in forms
	wire logic [31:0] b_inv = is_sub ? ~alu_b : alu_b;
	wire logic cin = ((op_r == OP_ADD_WITH_CARRY_OP) || (op_r == OP_SUB_WITH_BORROW_OP)) ? carry_r : is_sub;
	wire logic [32:0] sum = {1'b0, acc_r} + {1'b0, b_inv} + {32'h00000000, cin};
	wire logic ovf = (is_add || is_sub) && (acc_r[31] == b_inv[31]) && (sum[31] != acc_r[31]);
	wire logic [31:0] sat_val = acc_r[31] ? ACC_MIN : ACC_MAX;
	wire logic [31:0] arith_res = (ovf && saturate_enable_r) ? sat_val : sum[31:0];
	wire logic high16 = (shift_r == SHIFT_HIGH) && ((op_r == OP_ADD) || (op_r == OP_SUB));

	// Accumulator result and carry per operation
	logic [31:0] acc_nxt;
	logic carry_nxt;
	always_comb begin
		acc_nxt = acc_r;
		carry_nxt = carry_r;
		if (is_add || is_sub) begin
			acc_nxt = arith_res;
			if (!high16) begin
				carry_nxt = sum[32];
			end else if ((op_r == OP_ADD) && sum[32]) begin
				carry_nxt = 1'b1;
			end else if ((op_r == OP_SUB) && !sum[32]) begin
				carry_nxt = 1'b0;
			end
		end else if (is_load) begin
			acc_nxt = alu_b;
		end else begin
			case (op_r)
				OP_AND: acc_nxt = acc_r & alu_b;
				OP_OR: acc_nxt = acc_r | alu_b;
				OP_XOR: acc_nxt = acc_r ^ alu_b;
				OP_SFL: begin
					acc_nxt = {acc_r[30:0], 1'b0};
					carry_nxt = acc_r[31];
				end
				OP_SFR: begin
					acc_nxt = {sxm_r & acc_r[31], acc_r[31:1]};
					carry_nxt = acc_r[0];
				end
				OP_ROL: begin
					acc_nxt = {acc_r[30:0], carry_r};
					carry_nxt = acc_r[31];
				end
				OP_ROR: begin
					acc_nxt = {carry_r, acc_r[31:1]};
					carry_nxt = acc_r[0];
				end
				default: acc_nxt = acc_r;
			endcase
		end
	end

	// Branch evaluation
	logic cond_true;
	always_comb begin
		case (shift_r)
			COND_OV: cond_true = arith_wrap_flag_r;
			COND_EQ: cond_true = (acc_r == '0);
			COND_C: cond_true = carry_r;
			COND_NC: cond_true = !carry_r;
			default: cond_true = 1'b0;
		endcase
	end
	wire logic take_branch = (op_r == OP_BRANCH_TO_ACCUMULATOR_OP) || ((op_r == OP_BCOND) && cond_true);
	wire logic ov_clear_br = exec && (op_r == OP_BCOND) && (shift_r == COND_OV);
	wire logic ov_set = exec && ovf && !is_logic;

	// Next state of the sequencer
	always_comb begin
		case (st_r)
			ST_IDLE: st_nxt = wr_cmd ? ST_RUN : ST_IDLE;
			ST_RUN: st_nxt = (op_r == OP_MPYI) ? ST_IMM2 : (last_pass ? ST_IDLE : ST_RUN);
			ST_IMM2: st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
	end

	// Sequencer and command latch
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_r <= ST_IDLE;
			op_r <= OP_NOP;
			shift_r <= '0;
			rpt_r <= '0;
			imm_r <= '0;
		end else begin
			st_r <= st_nxt;
			if (wr_cmd) begin
				op_r <= op_type'(i_pwdata[CMD_OP_LSB +: OP_W]);
				shift_r <= i_pwdata[CMD_SHIFT_LSB +: SHIFT_W];
				rpt_r <= i_pwdata[CMD_RPT_LSB +: RPT_W];
				imm_r <= i_pwdata[CMD_IMM_LSB +: IMM_W];
			end else if (exec && is_mac && !last_pass) begin
				rpt_r <= rpt_r - 1'b1;
			end
		end
	end

	// Control and status bits; hardware set wins over clears
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			product_shift_select_r <= PSEL_RESET;
			saturate_enable_r <= SAT_RESET;
			sxm_r <= SXM_RESET;
			carry_r <= CARRY_RESET;
			arith_wrap_flag_r <= 1'b0;
			tc_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				product_shift_select_r <= i_pwdata[CTRL_PSEL_LSB +: 2];
				saturate_enable_r <= i_pwdata[CTRL_SAT_BIT];
				sxm_r <= i_pwdata[CTRL_SXM_BIT];
			end
			if (exec) begin
				carry_r <= carry_nxt;
			end else if (wr_status) begin
				carry_r <= i_pwdata[ST_CARRY_BIT];
			end
			if (ov_set) begin
				arith_wrap_flag_r <= 1'b1;
			end else if (ov_clear_br) begin
				arith_wrap_flag_r <= 1'b0;
			end else if (wr_status) begin
				arith_wrap_flag_r <= i_pwdata[ST_WRAP_BIT];
			end
			if (exec && (op_r == OP_BIT_TEST_VARIABLE_OP)) begin
				tc_r <= data_r[multiplier_operand_reg_r[3:0]];
			end else if (wr_status) begin
				tc_r <= i_pwdata[ST_TC_BIT];
			end
		end
	end

	// Operand, data word, product and accumulator
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			multiplier_operand_reg_r <= '0;
			data_r <= '0;
			product_reg_r <= '0;
			acc_r <= '0;
			store_r <= '0;
		end else begin
			if (exec && (loads_operand || is_mac)) begin
				multiplier_operand_reg_r <= is_mac ? i_sample_word : data_r;
			end else if (wr_operand) begin
				multiplier_operand_reg_r <= i_pwdata[15:0];
			end
			if (wr_data) begin
				data_r <= i_pwdata[15:0];
			end
			if (exec && (is_mac || (op_r == OP_MPY) || (op_r == OP_UNSIGNED_MULTIPLY_OP) || (op_r == OP_MPYI))) begin
				product_reg_r <= product;
			end else if (exec && (op_r == OP_LPH)) begin
				product_reg_r[31:16] <= data_r;
			end
			if (exec) begin
				acc_r <= acc_nxt;
			end
			if (exec && (op_r == OP_SPH)) begin
				store_r <= pshift[31:16];
			end else if (exec && (op_r == OP_SPL)) begin
				store_r <= pshift[15:0];
			end
		end
	end

	// Sample move and branch outputs
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			move_we_r <= 1'b0;
			move_data_r <= '0;
			branch_r <= 1'b0;
			target_r <= '0;
		end else begin
			move_we_r <= exec && ((op_r == OP_MULTIPLY_ACCUMULATE_MOVE_OP) || (op_r == OP_LTD));
			if (exec && (op_r == OP_MULTIPLY_ACCUMULATE_MOVE_OP)) begin
				move_data_r <= i_sample_word;
			end else if (exec && (op_r == OP_LTD)) begin
				move_data_r <= data_r;
			end
			branch_r <= exec && take_branch;
			if (exec && take_branch) begin
				target_r <= (op_r == OP_BRANCH_TO_ACCUMULATOR_OP) ? acc_r[15:0] : data_r;
			end
		end
	end

	// Read data mux
	wire logic [31:0] rd_ctrl = {28'h0000000, sxm_r, saturate_enable_r, product_shift_select_r};
	wire logic [31:0] rd_status = {28'h0000000, (acc_r == '0), tc_r, arith_wrap_flag_r, carry_r};
	wire logic [31:0] rd_val = hit_ctrl ? rd_ctrl :
		hit_status ? rd_status :
		hit_operand ? {16'h0000, multiplier_operand_reg_r} :
		hit_data ? {16'h0000, data_r} :
		hit_cmd ? {3'h0, imm_r, rpt_r, shift_r, op_r} :
		hit_prod ? product_reg_r :
		hit_acc ? acc_r :
		hit_store ? {16'h0000, store_r} :
		hit_target ? {16'h0000, target_r} : 32'h00000000;

	// APB answer registers, taken in the setup cycle
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end else if (i_psel && !i_penable) begin
			prdata_r <= i_pwrite ? 32'h00000000 : rd_val;
			pslverr_r <= !hit_any;
		end
	end

	// Outputs
	assign o_prdata = prdata_r;
	assign o_pready = !cmd_stall;
	assign o_pslverr = pslverr_r && apb_acc;
	assign o_coef_advance = exec && is_mac;
	assign o_sample_advance = exec && is_mac;
	assign o_move_we = move_we_r;
	assign o_move_data = move_data_r;
	assign o_branch_taken = branch_r;
	assign o_branch_target = target_r;
	assign o_busy = (st_r != ST_IDLE);

endmodule

// ===== mac_alu_checker.sv
// Assertion checker for the multiply/ALU datapath, bound to its top module.
// Assumes the design package is compiled first and APB byte addresses.
`timescale 1ns/100ps
module mac_alu_checker
	import mac_alu_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// APB side
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	// Streams, moves and branches
	input wire logic [15:0] i_sample_word,
	input wire logic o_coef_advance,
	input wire logic o_sample_advance,
	input wire logic o_move_we,
	input wire logic [15:0] o_move_data,
	input wire logic o_branch_taken,
	input wire logic o_busy
);
	// Accepted command write and its operation field
	wire cmd_wr = i_psel & i_penable & i_pwrite & o_pready & (i_paddr[7:0] == CMD_OFS);
	wire [4:0] cmd_op = i_pwdata[4:0];
	wire cmd_mac = (cmd_op == OP_MAC) | (cmd_op == OP_MULTIPLY_ACCUMULATE_MOVE_OP);
	logic [6:0] adv_cnt_r;
	logic [5:0] rpt_r;
	logic mac_r;

	// Counts stream fetches of the command in flight
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			adv_cnt_r <= 7'h00;
			rpt_r <= 6'h00;
			mac_r <= 1'b0;
		end else if (cmd_wr) begin
			adv_cnt_r <= 7'h00;
			rpt_r <= i_pwdata[15:10];
			mac_r <= cmd_mac;
		end else if (o_coef_advance) begin
			adv_cnt_r <= adv_cnt_r + 7'h01;
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	property p_adv_pair;
		(o_coef_advance || o_sample_advance) |-> (o_coef_advance && o_sample_advance && o_busy);
	endproperty
	a_adv_pair: assert property (p_adv_pair) else $error("fetch strobes not paired");
	property p_adv_count;
		mac_r && $fell(o_busy) |-> adv_cnt_r == 7'(rpt_r) + 7'h01;
	endproperty
	a_adv_count: assert property (p_adv_count) else $error("wrong fetch count");
	property p_no_adv;
		cmd_wr && !cmd_mac |=> !o_coef_advance;
	endproperty
	a_no_adv: assert property (p_no_adv) else $error("fetch outside accumulate");
	property p_mpyi;
		cmd_wr && cmd_op == OP_MPYI |=> o_busy [*2] ##1 !o_busy;
	endproperty
	a_mpyi: assert property (p_mpyi) else $error("immediate multiply not two cycles");
	property p_mpy;
		cmd_wr && (cmd_op == OP_MPY || cmd_op == OP_UNSIGNED_MULTIPLY_OP) |=> o_busy ##1 !o_busy;
	endproperty
	a_mpy: assert property (p_mpy) else $error("multiply not single cycle");
	property p_move_src;
		o_move_we && $past(o_sample_advance) |-> o_move_data == $past(i_sample_word);
	endproperty
	a_move_src: assert property (p_move_src) else $error("moved sample differs");
	property p_move_cause;
		o_move_we |-> $past(o_busy);
	endproperty
	a_move_cause: assert property (p_move_cause) else $error("move without command");
	property p_branch;
		o_branch_taken |-> $past(o_busy) && !o_busy;
	endproperty
	a_branch: assert property (p_branch) else $error("branch pulse misplaced");
endmodule

bind mac_alu mac_alu_checker #(.ADDR_W(ADDR_W)) u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_pready(o_pready), .i_sample_word(i_sample_word), .o_coef_advance(o_coef_advance),
	.o_sample_advance(o_sample_advance), .o_move_we(o_move_we), .o_move_data(o_move_data),
	.o_branch_taken(o_branch_taken), .o_busy(o_busy));

// ===== tb.sv
// Self-checking bench for the multiply/ALU datapath over APB.
// Assumes package, design and checker are compiled first.
`timescale 1ns/100ps
module tb;
	import mac_alu_pkg::*;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, prd, q;
	logic rdy, err, adv, sadv, mwe, bt, busy, qe;
	logic [15:0] cw, sw, md, bta;
	logic [15:0] ct [32];
	logic [15:0] st [32];
	logic [15:0] sq [$];
	int errors = 0, checks_done = 0, idx = 0, advn = 0, movn = 0, brn = 0;

	always #20 clk = ~clk;

	mac_alu DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
		.i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_coef_word(cw), .i_sample_word(sw),
		.o_coef_advance(adv), .o_sample_advance(sadv), .o_move_we(mwe), .o_move_data(md),
		.o_branch_taken(bt), .o_branch_target(bta), .o_busy(busy));

	task chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask

	task wrap_up;
		if (errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// One APB transfer; ready and the answer are taken at the edge ending the access
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 500);
		if (rdy !== 1'b1) begin
			errors++;
			wrap_up;
		end
		q = prd;
		qe = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	// Command write, then wait until the sequencer is idle again
	task cmd(input op_type op, input logic [4:0] sh, input logic [5:0] rp, input logic [12:0] im);
		int n;
		apb(1'b1, CMD_OFS, {3'h0, im, rp, sh, op});
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy !== 1'b0 && n < 500);
		if (busy !== 1'b0) begin
			errors++;
			wrap_up;
		end
	endtask

	task br(input op_type op, input logic [4:0] c, input int tk, input logic [15:0] t);
		int b0;
		b0 = brn;
		cmd(op, c, 6'h0, 13'h0);
		apb(1'b0, TARGET_OFS, 32'h0);
		chk(brn - b0, tk);
		if (tk) chk(q, {16'h0, t});
		if (tk) chk({16'h0, bta}, {16'h0, t});
	endtask

	task ovf(input logic [15:0] d, input logic [31:0] acc, input logic [31:0] stat);
		apb(1'b1, DATA_OFS, {16'h0, d});
		cmd(OP_LACC, SHIFT_HIGH, 6'h0, 13'h0);
		cmd(OP_ADD, SHIFT_HIGH, 6'h0, 13'h0);
		rd_chk(ACC_OFS, acc);
		rd_chk(STATUS_OFS, stat);
	endtask

	// Product as it leaves the product shifter
	function automatic logic [31:0] psh(input logic [31:0] p, input logic [1:0] s);
		case (s)
			PSEL_NONE: return p;
			PSEL_LEFT1: return p << PSH_LEFT1;
			PSEL_LEFT4: return p << PSH_LEFT4;
			default: return $signed(p) >>> PSH_RIGHT6;
		endcase
	endfunction

	// Coefficient/sample source and observers of moves and branches
	always @(posedge clk) begin
		if ((adv | sadv) !== 1'b0) chk({30'h0, adv, sadv}, 32'h3);
		if (adv === 1'b1) begin
			sq.push_back(sw);
			idx <= idx + 1;
			cw <= ct[idx+1];
			sw <= st[idx+1];
			advn <= advn + 1;
		end
		if (mwe === 1'b1) begin
			movn <= movn + 1;
			chk({16'h0, md}, {16'h0, sq.pop_front()});
		end
		if (bt === 1'b1) brn <= brn + 1;
	end

	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		wrap_up;
	end

	initial begin
		logic [15:0] a, b, d;
		logic [31:0] p, x;
		int n, k0, a0, m0;
		void'($urandom(26));
		for (int i = 0; i < 32; i++) begin
			ct[i] = 16'($urandom) & 16'h0fff;
			st[i] = 16'($urandom) & 16'h0fff;
		end
		cw <= ct[0];
		sw <= st[0];
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd_chk(STATUS_OFS, 32'h9);
		rd_chk(CTRL_OFS, 32'h8);
		apb(1'b0, 8'h24, 32'h0);
		chk({31'h0, qe}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			a = 16'($urandom);
			b = 16'($urandom);
			apb(1'b1, OPERAND_OFS, {16'h0, a});
			apb(1'b1, DATA_OFS, {16'h0, b});
			cmd(OP_MPY, 5'h0, 6'h0, 13'h0);
			p = $signed(a) * $signed(b);
			rd_chk(PROD_OFS, p);
			cmd(OP_UNSIGNED_MULTIPLY_OP, 5'h0, 6'h0, 13'h0);
			p = a * b;
			rd_chk(PROD_OFS, p);
			for (int s = 0; s < 4; s++) begin
				apb(1'b1, CTRL_OFS, 32'h8 | 32'(s));
				x = psh(p, 2'(s));
				cmd(OP_SPH, 5'h0, 6'h0, 13'h0);
				rd_chk(STORE_OFS, {16'h0, x[31:16]});
				cmd(OP_SPL, 5'h0, 6'h0, 13'h0);
				rd_chk(STORE_OFS, {16'h0, x[15:0]});
				cmd(OP_LTP, 5'h0, 6'h0, 13'h0);
				rd_chk(ACC_OFS, x);
				rd_chk(OPERAND_OFS, {16'h0, b});
				rd_chk(PROD_OFS, p);
			end
		end
		apb(1'b1, CTRL_OFS, 32'h8);
		cmd(OP_MPYI, 5'h0, 6'h0, 13'h0);
		rd_chk(PROD_OFS, 32'h0);
		apb(1'b1, OPERAND_OFS, {16'h0, a});
		cmd(OP_MPYI, 5'h0, 6'h0, 13'h1);
		apb(1'b0, PROD_OFS, 32'h0);
		chk({16'h0, q[15:0]}, {16'h0, a});
		cmd(OP_LPH, 5'h0, 6'h0, 13'h0);
		rd_chk(PROD_OFS, {b, a});
		d = 16'($urandom);
		cmd(OP_MPYI, 5'h0, 6'h0, d[12:0]);
		p = $signed(a) * $signed(d[12:0]);
		rd_chk(PROD_OFS, p);
		for (int i = 0; i < 4; i++) begin
			n = $urandom % 16;
			d = 16'($urandom) & 16'h7fff;
			apb(1'b1, OPERAND_OFS, {16'h0, 12'($urandom), 4'(n)});
			apb(1'b1, DATA_OFS, {16'h0, d});
			cmd(OP_LOAD_WITH_VARIABLE_SHIFT_OP, 5'h0, 6'h0, 13'h0);
			p = {16'h0, d} << n;
			rd_chk(ACC_OFS, p);
			cmd(OP_ADD_WITH_VARIABLE_SHIFT_OP, 5'h0, 6'h0, 13'h0);
			rd_chk(ACC_OFS, p << 1);
			cmd(OP_BIT_TEST_VARIABLE_OP, 5'h0, 6'h0, 13'h0);
			rd_chk(ACC_OFS, p << 1);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk({31'h0, q[ST_TC_BIT]}, {31'h0, d[n]});
		end
		// Product pipelined into the accumulator, then shifts and logic
		apb(1'b1, OPERAND_OFS, 32'h3);
		apb(1'b1, DATA_OFS, 32'h5);
		cmd(OP_MPY, 5'h0, 6'h0, 13'h0);
		cmd(OP_LACC, 5'h0, 6'h0, 13'h0);
		cmd(OP_LTA, 5'h0, 6'h0, 13'h0);
		rd_chk(ACC_OFS, 32'h14);
		cmd(OP_LTS, 5'h0, 6'h0, 13'h0);
		rd_chk(ACC_OFS, 32'h5);
		apb(1'b1, DATA_OFS, 32'h8001);
		cmd(OP_LACC, SHIFT_HIGH, 6'h0, 13'h0);
		apb(1'b1, STATUS_OFS, 32'h0);
		cmd(OP_SFL, 5'h0, 6'h0, 13'h0);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk({31'h0, q[ST_CARRY_BIT]}, 32'h1);
		cmd(OP_ROR, 5'h0, 6'h0, 13'h0);
		rd_chk(ACC_OFS, 32'h80010000);
		apb(1'b1, DATA_OFS, 32'hff);
		cmd(OP_XOR, 5'h0, 6'h0, 13'h0);
		rd_chk(ACC_OFS, 32'h800100ff);
		cmd(OP_SUB, 5'h0, 6'h0, 13'h0);
		rd_chk(ACC_OFS, 32'h80010000);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk({31'h0, q[ST_CARRY_BIT]}, 32'h1);
		apb(1'b1, CTRL_OFS, 32'hc);
		apb(1'b1, STATUS_OFS, 32'h0);
		ovf(16'h7fff, ACC_MAX, 32'h2);
		apb(1'b1, STATUS_OFS, 32'h0);
		cmd(OP_OR, 5'h0, 6'h0, 13'h0);
		rd_chk(STATUS_OFS, 32'h0);
		ovf(16'h8000, ACC_MIN, 32'h3);
		apb(1'b1, CTRL_OFS, 32'h8);
		apb(1'b1, STATUS_OFS, 32'h0);
		ovf(16'h7fff, 32'hfffe0000, 32'h2);
		cmd(OP_LACC, 5'h0, 6'h0, 13'h0);
		rd_chk(STATUS_OFS, 32'h2);
		br(OP_BCOND, COND_OV, 1, 16'h7fff);
		rd_chk(STATUS_OFS, 32'h0);
		apb(1'b1, DATA_OFS, 32'h1234);
		cmd(OP_LACC, 5'h0, 6'h0, 13'h0);
		apb(1'b1, STATUS_OFS, 32'h1);
		apb(1'b1, DATA_OFS, 32'h0100);
		cmd(OP_ADD_WITH_CARRY_OP, 5'h0, 6'h0, 13'h0);
		rd_chk(ACC_OFS, 32'h1335);
		apb(1'b1, STATUS_OFS, 32'h0);
		cmd(OP_SUB_WITH_BORROW_OP, 5'h0, 6'h0, 13'h0);
		rd_chk(ACC_OFS, 32'h1234);
		apb(1'b1, DATA_OFS, 32'h0);
		cmd(OP_LACC, 5'h0, 6'h0, 13'h0);
		apb(1'b1, DATA_OFS, 32'h5a3c);
		br(OP_BCOND, COND_EQ, 1, 16'h5a3c);
		cmd(OP_LACC, 5'h0, 6'h0, 13'h0);
		br(OP_BCOND, COND_EQ, 0, 16'h0);
		apb(1'b1, DATA_OFS, 32'h0f0f);
		br(OP_BRANCH_TO_ACCUMULATOR_OP, 5'h0, 1, 16'h5a3c);
		apb(1'b1, STATUS_OFS, 32'h1);
		br(OP_BCOND, COND_C, 1, 16'h0f0f);
		br(OP_BCOND, COND_NC, 0, 16'h0);
		br(OP_BCOND, 5'h4, 0, 16'h0);
		for (int j = 0; j < 2; j++) begin
			apb(1'b1, DATA_OFS, 32'h0);
			cmd(OP_LACC, 5'h0, 6'h0, 13'h0);
			cmd(OP_MPYI, 5'h0, 6'h0, 13'h0);
			n = 3 + $urandom % 7;
			k0 = idx;
			a0 = advn;
			m0 = movn;
			sq.delete();
			cmd(j ? OP_MULTIPLY_ACCUMULATE_MOVE_OP : OP_MAC, 5'h0, 6'(n), 13'h0);
			p = 32'h0;
			for (int k = 0; k < n; k++) p += ct[k0+k] * st[k0+k];
			rd_chk(ACC_OFS, p);
			rd_chk(PROD_OFS, ct[k0+n] * st[k0+n]);
			rd_chk(OPERAND_OFS, {16'h0, st[k0+n]});
			chk(advn - a0, n + 1);
			chk(movn - m0, j * (n + 1));
		end
		wrap_up;
	end
endmodule
